//--- logic/parity_calc.sv
// Purpose: Parity bit over a data word
// Assumes: Purely combinational, sampled by the caller's register
// Notes: ODD selects whether word plus parity holds an odd count of ones
module parity_calc #(
	parameter int W = 15,
	parameter logic ODD = 1'b1
) (
	// Data in
	input wire logic [W-1:0] data_i,
	// Parity out
	output logic par_o
);

	// Reduction xor, inverted for odd sense
	assign par_o = (^data_i) ^ ODD;

endmodule : parity_calc

//--- logic/result_bank.sv
// Purpose: Per-channel result store with parallel load and registered read
// Assumes: Load wins over a flag clear in the same cycle
// Notes: Indices at or above N read as zero
module result_bank #(
	parameter int N = 15,
	parameter int W = 15,
	parameter int IW = 4,
	parameter int FLAG = 14
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Parallel load from the result buffer
	input wire logic load_i,
	input wire logic [N-1:0][W-1:0] load_data_i,
	// Per-entry flag clear
	input wire logic [N-1:0] clr_flag_i,
	// Read port
	input wire logic rd_en_i,
	input wire logic [IW-1:0] rd_idx_i,
	output logic [W-1:0] rd_data_o
);

	logic [N-1:0][W-1:0] mem_q;

	// One entry per channel; a fresh load beats a clear
	for (genvar e = 0; e < N; e++) begin : g_entry
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				mem_q[e] <= '0;
			end else if (load_i) begin
				mem_q[e] <= load_data_i[e];
			end else if (clr_flag_i[e]) begin
				mem_q[e][FLAG] <= 1'b0;
			end
		end
	end

	// Registered read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_o <= '0;
		end else if (rd_en_i) begin
			rd_data_o <= (rd_idx_i < IW'(N)) ? mem_q[rd_idx_i] : '0;
		end
	end

endmodule : result_bank

//--- logic/seq_readout_pkg.sv
// Purpose: Shared constants and types for the sequencer result readout block
// Assumes: Wishbone classic slave, 32-bit data, 16-bit registers in the low half
// Notes: Register index times four gives the byte address
package seq_readout_pkg;

	// Bus geometry
	localparam int ADR_W = 10;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 8;

	// Register indices
	localparam logic [IDX_W-1:0] IDX_COPY = 8'hDF;
	localparam logic [IDX_W-1:0] IDX_COMP = 8'hE0;
	localparam logic [IDX_W-1:0] IDX_RES_FIRST = 8'hE1;
	localparam logic [IDX_W-1:0] IDX_RES_LAST = 8'hEF;
	localparam logic [IDX_W-1:0] IDX_CTRL = 8'hF0;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'hF1;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'hF2;

	// Channel and field layout
	localparam int CHAN_N = 15;
	localparam int CH_IDX_W = 4;
	localparam int RES_W = 15;
	localparam int FLAG_BIT = 14;
	localparam int VOLT_W = 12;
	localparam int PAR_BIT = 15;
	localparam logic MEAS_RES = 1'b0;
	localparam logic MEAS_VOLT = 1'b1;

	// Control register: bit 0 lets a sync edge copy results
	localparam int CTRL_SYNC_COPY = 0;
	localparam logic CTRL_SYNC_COPY_RST = 1'b1;

	// Interrupt status bits
	localparam int IRQ_N = 3;
	localparam int IRQ_HOST_COPY = 0;
	localparam int IRQ_SYNC_COPY = 1;
	localparam int IRQ_COMP_CHG = 2;

	// Parity sense: 1 makes the 16-bit word hold an odd count of ones
	localparam logic PAR_ODD = 1'b1;

	// Bus access sequencer
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_ACK = 3'b100
	} bus_state_t;

	// Wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [ADR_W-1:0] adr;
		logic [31:0] dat;
	} wb_req_t;

endpackage : seq_readout_pkg

//--- logic/sequencer_result_readout.sv
// Purpose: Result readout register group of a sensor sequencer on Wishbone
// Assumes: Result buffer, freshness, type and comparator inputs are synchronous
// Notes: Each access answers with ack two edges after the request is seen

// Function
// - Reading the copy trigger register loads the result buffer into result registers.
// - Comparator status bits 14..0 show each channel comparator output.
// - Fifteen result registers sit at consecutive indices, channel 1 lowest.
// - Resistance result holds the ratio value when fresh, otherwise zero.
// - Resistance value is unsigned 4.11 fixed point in bits 14..0.
// - Voltage result: bit 14 clear-on-read fresh flag, 13..12 zero, 11..0 value.
// - With sync copy enabled (reset default) a sync edge also copies.
// - Per-channel type bit: 0 resistance format, 1 voltage format.
module sequencer_result_readout (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire seq_readout_pkg::wb_req_t wb_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	// Sequencer result buffer
	input wire logic [seq_readout_pkg::CHAN_N-1:0][seq_readout_pkg::RES_W-1:0] result_buf_i,
	input wire logic [seq_readout_pkg::CHAN_N-1:0] result_fresh_i,
	input wire logic [seq_readout_pkg::CHAN_N-1:0] measure_type_select_i,
	// Comparators and sync
	input wire logic [seq_readout_pkg::CHAN_N-1:0] comparator_i,
	input wire logic sync_i,
	// Interrupt
	output logic irq_o
);
	import seq_readout_pkg::*;

	bus_state_t state_q;
	logic req;
	logic [IDX_W-1:0] idx;
	logic [IDX_W-1:0] res_off;
	logic [CH_IDX_W-1:0] res_sel;
	logic is_res;
	logic acc;
	logic rd_acc;
	logic wr_acc;
	logic host_copy;
	logic sync_q;
	logic armed_q;
	logic sync_edge;
	logic sync_copy;
	logic copy;
	logic [CHAN_N-1:0][RES_W-1:0] load_data;
	logic [CHAN_N-1:0] clr_flag;
	logic [RES_W-1:0] bank_rd;
	logic [CHAN_N-1:0] comp_q;
	logic ctrl_sync_copy_q;
	logic [IRQ_N-1:0] irq_stat_q;
	logic [IRQ_N-1:0] irq_stat_d;
	logic [IRQ_N-1:0] irq_mask_q;
	logic [IRQ_N-1:0] irq_ev;
	logic [IRQ_N-1:0] irq_w1c;
	logic [RES_W-1:0] rdata;
	logic rpar;

	// Request decode from the held master signals
	assign req = wb_i.cyc & wb_i.stb;
	assign idx = wb_i.adr[ADR_W-1:IDX_LSB];
	assign res_off = idx - IDX_RES_FIRST;
	assign res_sel = res_off[CH_IDX_W-1:0];
	assign is_res = (idx >= IDX_RES_FIRST) && (idx <= IDX_RES_LAST);

	// Access takes effect at the edge that raises ack
	assign acc = (state_q == ST_FETCH);
	assign rd_acc = acc & ~wb_i.we;
	assign wr_acc = acc & wb_i.we;

	// Bus sequencer: idle, fetch (bank read settles), ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (req) begin
						state_q <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					state_q <= ST_ACK;
				end
				ST_ACK: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Ack is high for exactly one cycle per access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= acc;
		end
	end

	// Copy triggers: host read of the trigger register or an enabled sync edge
	assign host_copy = rd_acc && (idx == IDX_COPY);
	assign sync_edge = armed_q & (sync_i ^ sync_q);
	assign sync_copy = sync_edge & ctrl_sync_copy_q;
	assign copy = host_copy | sync_copy;

	// Sync history; armed blocks a false edge right after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			sync_q <= sync_i;
			armed_q <= 1'b1;
		end
	end

	// Per-channel formatting of buffer data into result words
	for (genvar c = 0; c < CHAN_N; c++) begin : g_chan
		always_comb begin
			if (measure_type_select_i[c] == MEAS_VOLT) begin
				load_data[c] = {result_fresh_i[c], 2'b00,
					result_buf_i[c][VOLT_W-1:0]};
			end else if (result_fresh_i[c]) begin
				load_data[c] = result_buf_i[c];
			end else begin
				load_data[c] = '0;
			end
		end
		// Only a voltage-format read clears the fresh flag
		assign clr_flag[c] = rd_acc && is_res && (res_sel == CH_IDX_W'(c))
			&& (measure_type_select_i[c] == MEAS_VOLT);
	end

	// Result store for the fifteen channel registers
	result_bank #(
		.N(CHAN_N),
		.W(RES_W),
		.IW(CH_IDX_W),
		.FLAG(FLAG_BIT)
	) u_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(copy),
		.load_data_i(load_data),
		.clr_flag_i(clr_flag),
		.rd_en_i(req && (state_q == ST_IDLE)),
		.rd_idx_i(is_res ? res_sel : CH_IDX_W'(CHAN_N)),
		.rd_data_o(bank_rd)
	);

	// Comparator status follows the comparators every cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			comp_q <= '0;
		end else begin
			comp_q <= comparator_i;
		end
	end

	// Control register: sync copy enable, set after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_sync_copy_q <= CTRL_SYNC_COPY_RST;
		end else if (wr_acc && (idx == IDX_CTRL) && wb_i.sel[0]) begin
			ctrl_sync_copy_q <= wb_i.dat[CTRL_SYNC_COPY];
		end
	end

	// Interrupt events and write-one-to-clear; a new event beats its clear
	assign irq_ev[IRQ_HOST_COPY] = host_copy;
	assign irq_ev[IRQ_SYNC_COPY] = sync_copy;
	assign irq_ev[IRQ_COMP_CHG] = armed_q && (comp_q != comparator_i);
	assign irq_w1c = (wr_acc && (idx == IDX_IRQ_STAT) && wb_i.sel[0])
		? wb_i.dat[IRQ_N-1:0] : '0;
	assign irq_stat_d = (irq_stat_q & ~irq_w1c) | irq_ev;

	// Sticky status and mask registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
		end else begin
			irq_stat_q <= irq_stat_d;
			if (wr_acc && (idx == IDX_IRQ_MASK) && wb_i.sel[0]) begin
				irq_mask_q <= wb_i.dat[IRQ_N-1:0];
			end
		end
	end

	// Interrupt level from the registered status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Read mux; unmapped indices and the trigger read as zero
	always_comb begin
		rdata = '0;
		if (idx == IDX_COPY) begin
			rdata = '0;
		end else if (idx == IDX_COMP) begin
			rdata = comp_q;
		end else if (is_res) begin
			rdata = bank_rd;
		end else if (idx == IDX_CTRL) begin
			rdata[CTRL_SYNC_COPY] = ctrl_sync_copy_q;
		end else if (idx == IDX_IRQ_STAT) begin
			rdata[IRQ_N-1:0] = irq_stat_q;
		end else if (idx == IDX_IRQ_MASK) begin
			rdata[IRQ_N-1:0] = irq_mask_q;
		end
	end

	// Parity over the fifteen data bits
	parity_calc #(
		.W(RES_W),
		.ODD(PAR_ODD)
	) u_par (
		.data_i(rdata),
		.par_o(rpar)
	);

	// Read data register; bit 15 is parity, upper half zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (rd_acc) begin
			wb_dat_o <= {16'h0000, rpar, rdata};
		end else if (acc) begin
			wb_dat_o <= '0;
		end
	end

	// Checks on the block's own behaviour
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	ack_timing_a: assert property (
		(state_q == ST_IDLE && req) |-> !wb_ack_o ##2 wb_ack_o ##1 !wb_ack_o
	) else $error("ack not two edges after request");

	host_copy_a: assert property (
		(rd_acc && idx == IDX_COPY) |=> irq_stat_q[IRQ_HOST_COPY]
	) else $error("trigger read did not copy");

	sync_copy_a: assert property (
		(armed_q && sync_i != $past(sync_i) && ctrl_sync_copy_q) |-> copy
	) else $error("enabled sync edge did not copy");

	sync_off_a: assert property (
		(!ctrl_sync_copy_q && !(rd_acc && idx == IDX_COPY)) |-> !copy
	) else $error("copy without trigger");

	comp_track_a: assert property (
		armed_q |-> comp_q == $past(comparator_i)
	) else $error("comparator status lags");

	res_last_a: assert property (
		(acc && idx == IDX_RES_LAST) |-> is_res && res_sel == CH_IDX_W'(CHAN_N - 1)
	) else $error("last result index wrong");

	volt_zero_a: assert property (
		(rd_acc && is_res && measure_type_select_i[res_sel] == MEAS_VOLT
			&& $stable(measure_type_select_i) && !$past(copy))
			|=> wb_dat_o[13:12] == 2'b00
	) else $error("voltage reserved bits not zero");

	res_stale_a: assert property (
		(copy && !result_fresh_i[0] && measure_type_select_i[0] == MEAS_RES)
			|-> load_data[0] == '0
	) else $error("stale resistance not zero");

	parity_a: assert property (
		(wb_ack_o && $past(rd_acc)) |-> (^wb_dat_o[PAR_BIT:0]) == PAR_ODD
	) else $error("parity bit wrong");

	upper_zero_a: assert property (
		wb_ack_o |-> wb_dat_o[31:16] == 16'h0000
	) else $error("upper half not zero");

	irq_level_a: assert property (
		(|(irq_stat_q & irq_mask_q)) |=> irq_o
	) else $error("unmasked status without interrupt");

	// Handshake shape, read side effects and register decode
	ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o
	) else $error("ack longer than one cycle");

	ack_source_a: assert property (
		wb_ack_o |-> $past(state_q) == ST_FETCH
	) else $error("ack without a fetched request");

	comp_read_a: assert property (
		(rd_acc && idx == IDX_COMP) |=> wb_dat_o[RES_W-1:0] == $past(comp_q)
	) else $error("comparator status read wrong");

	trig_read_a: assert property (
		(rd_acc && idx == IDX_COPY) |=> wb_dat_o[RES_W-1:0] == 15'h0000
	) else $error("trigger register data not zero");

	res_first_a: assert property (
		(idx == IDX_RES_FIRST) |-> is_res && res_sel == CH_IDX_W'(0)
	) else $error("first result index wrong");

	res_bound_a: assert property (
		is_res |-> res_sel < CH_IDX_W'(CHAN_N)
	) else $error("result index beyond last channel");

	volt_load_a: assert property (
		(measure_type_select_i[0] == MEAS_VOLT) |-> load_data[0][RES_W-2:VOLT_W] == 2'b00
			&& load_data[0][FLAG_BIT] == result_fresh_i[0]
	) else $error("voltage result word malformed");

	res_fresh_a: assert property (
		(measure_type_select_i[0] == MEAS_RES && result_fresh_i[0])
			|-> load_data[0] == result_buf_i[0]
	) else $error("fresh resistance value altered");

	flag_clear_a: assert property (
		(rd_acc && idx == IDX_RES_FIRST && measure_type_select_i[0] == MEAS_VOLT)
			|-> clr_flag[0]
	) else $error("voltage read kept its flag");

	res_keep_a: assert property (
		(rd_acc && idx == IDX_RES_FIRST && measure_type_select_i[0] == MEAS_RES)
			|-> !clr_flag[0]
	) else $error("resistance read cleared a flag");

	ctrl_set_a: assert property (
		(wr_acc && idx == IDX_CTRL && wb_i.sel[0] && wb_i.dat[CTRL_SYNC_COPY])
			|=> ctrl_sync_copy_q
	) else $error("sync copy enable not set");

	irq_clear_a: assert property (
		(wr_acc && idx == IDX_IRQ_STAT && wb_i.sel[0] && wb_i.dat[IRQ_HOST_COPY])
			|=> !irq_stat_q[IRQ_HOST_COPY]
	) else $error("status bit not cleared");

	irq_quiet_a: assert property (
		!(|(irq_stat_q & irq_mask_q)) |=> !irq_o
	) else $error("interrupt without unmasked status");

endmodule : sequencer_result_readout

//--- test/tb_top.sv
// Purpose: Self-checking bench for the sequencer result readout block
// Assumes: Host model drives the bus, bench drives buffer and comparator inputs
// Notes: Parity is odd over the 16-bit word
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import seq_readout_pkg::*;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	wb_req_t wb_req;
	logic wb_ack;
	logic [31:0] wb_dat;
	logic [CHAN_N-1:0][RES_W-1:0] res_buf = '0;
	logic [CHAN_N-1:0] fresh = '0;
	logic [CHAN_N-1:0] mtype = '0;
	logic [CHAN_N-1:0] comp = '0;
	logic sync = 1'b0;
	logic irq;
	logic [31:0] rd;
	int num_errors = 0;
	int compares = 0;

	// Clock, 20 ns period
	always #10 clk_i = ~clk_i;

	// Block under test and host
	sequencer_result_readout u_sequencer_result_readout (
		.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req), .wb_ack_o(wb_ack), .wb_dat_o(wb_dat),
		.result_buf_i(res_buf), .result_fresh_i(fresh), .measure_type_select_i(mtype),
		.comparator_i(comp), .sync_i(sync), .irq_o(irq)
	);
	wb_host u_wb_host (.clk_i(clk_i), .ack_i(wb_ack), .dat_i(wb_dat), .req_o(wb_req));

	// Register word with odd parity on top
	function automatic logic [15:0] word(input logic [14:0] v);
		return {~^v, v};
	endfunction : word

	// Result value expected after a copy
	function automatic logic [14:0] exp_res(input int k);
		if (mtype[k] == MEAS_RES) begin
			return fresh[k] ? res_buf[k] : 15'h0000;
		end
		return {fresh[k], 2'b00, res_buf[k][11:0]};
	endfunction : exp_res

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic rd_chk(input logic [7:0] idx, input logic [14:0] v, input string nm);
		u_wb_host.xfer(1'b0, idx, 16'h0000, rd);
		chk(nm, {16'h0000, word(v)}, rd);
	endtask : rd_chk

	task automatic t_reset;
		rd_chk(IDX_COMP, 15'h0000, "comp status");
		rd_chk(IDX_CTRL, 15'h0001, "control");
		rd_chk(IDX_RES_FIRST, 15'h0000, "result 1");
		rd_chk(8'h10, 15'h0000, "unmapped");
	endtask : t_reset

	task automatic t_copy;
		int k;
		@(posedge clk_i);
		for (k = 0; k < CHAN_N; k++) begin
			res_buf[k] <= 15'h7000 + 15'(k * 15'h0111);
		end
		fresh <= 15'h2a5a;
		mtype <= 15'h0f0f;
		rd_chk(IDX_COPY, 15'h0000, "copy trigger");
		for (k = 0; k < CHAN_N; k++) begin
			rd_chk(IDX_RES_FIRST + 8'(k), exp_res(k), "result");
		end
		// Voltage flags are gone on the second read
		for (k = 0; k < CHAN_N; k++) begin
			rd_chk(IDX_RES_FIRST + 8'(k), exp_res(k) & (mtype[k] ? 15'h3fff : 15'h7fff), "reread");
		end
	endtask : t_copy

	task automatic t_comp;
		@(posedge clk_i);
		comp <= 15'h4c31;
		repeat (2) @(posedge clk_i);
		rd_chk(IDX_COMP, 15'h4c31, "comp status");
	endtask : t_comp

	task automatic t_sync;
		@(posedge clk_i);
		res_buf[0] <= 15'h1234;
		fresh <= 15'h7fff;
		mtype <= 15'h0000;
		@(posedge clk_i);
		sync <= ~sync;
		repeat (3) @(posedge clk_i);
		rd_chk(IDX_RES_FIRST, 15'h1234, "sync copy");
		u_wb_host.xfer(1'b1, IDX_CTRL, 16'h0000, rd);
		@(posedge clk_i);
		res_buf[0] <= 15'h0abc;
		@(posedge clk_i);
		sync <= ~sync;
		repeat (3) @(posedge clk_i);
		rd_chk(IDX_RES_FIRST, 15'h1234, "sync blocked");
	endtask : t_sync

	task automatic t_irq;
		u_wb_host.xfer(1'b1, IDX_IRQ_MASK, 16'h0001, rd);
		repeat (2) @(posedge clk_i);
		chk("irq raised", 32'h0000_0001, {31'h0000_0000, irq});
		u_wb_host.xfer(1'b1, IDX_IRQ_STAT, 16'h0001, rd);
		repeat (2) @(posedge clk_i);
		chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
		rd_chk(IDX_IRQ_STAT, 15'h0006, "irq status");
	endtask : t_irq

	// Mid-run reset clears results and restores the sync copy enable
	task automatic t_rst_again;
		@(posedge clk_i);
		rst_i <= 1'b1;
		comp <= '0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		chk("irq after reset", 32'h0000_0000, {31'h0000_0000, irq});
	endtask : t_rst_again

	task automatic close_out;
		if (num_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		t_copy;
		t_comp;
		t_sync;
		t_irq;
		t_rst_again;
		close_out;
	end

	// Watchdog
	initial begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		close_out;
	end
endmodule : tb_top

//--- test/wb_host.sv
// Purpose: Host model that reaches the readout registers over classic Wishbone
// Assumes: One access at a time, the slave always answers with ack
// Notes: Waits for ack without a cycle limit; the bench watchdog ends a hang
module wb_host (
	// Clock and answer
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	// Request
	output seq_readout_pkg::wb_req_t req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import seq_readout_pkg::*;

	// Bus idle from time zero
	initial begin
		req_o = '0;
	end

	// Single access: request held until the edge that samples ack
	task automatic xfer(input logic we, input logic [7:0] idx, input logic [15:0] wd,
			output logic [31:0] rd);
		@(posedge clk_i);
		req_o <= {1'b1, 1'b1, we, 4'hf, {idx, 2'b00}, {16'h0000, wd}};
		// Hold the request until ack is sampled high at an edge
		do begin
			@(posedge clk_i);
		end while (ack_i !== 1'b1);
		rd = dat_i;
		// Release right after the answer edge
		req_o.cyc <= 1'b0;
		req_o.stb <= 1'b0;
	endtask : xfer
endmodule : wb_host
